// file: hw/trd_timer.sv
// Notes on behaviour
// - Each channel: 8-bit latch plus down counter.
// - Reload mode reloads at zero, period latch+1.
// - Expiry event each time counter reaches zero.
// - Count register reads return current counter.
// - Count register writes preload the latch.
// - First period after enable may deviate one tick.
// - Slow taps from slow clock, fast from oscillator.
// - Slow codes select divide 16384 down to 64.
// - Timer0/1 fast codes divide 128..2, then undivided.
// - Timer1 code 000x cascades from Timer0 bit 7.
// - Timer2 cascades Timer1; fast codes divide 512..4.
// - Config bit 4: reload one, one-shot zero.
// - Timer0 config bit 5 enables tone, default on.
// - Timer0 bits 7:6 choose clock-stop condition.
// - Run bit 0 starts or stops channel, default off.
module trd_timer
    import trd_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [BUS_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [BUS_W-1:0] hwdata,
    input wire logic hready,
    output logic [BUS_W-1:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    input wire logic slow_clock,
    input wire logic fast_oscillator,
    input wire logic external_count_input,
    output logic [NUM_CH-1:0] channel_expiry,
    output logic tone_out,
    output logic irq
);

    // Pin conditioning: three stages, a change counts once 2 and 3 agree
    logic [NUM_PINS-1:0] sync1_q;
    logic [NUM_PINS-1:0] sync2_q;
    logic [NUM_PINS-1:0] sync3_q;
    logic [NUM_PINS-1:0] filt_q;
    logic [NUM_PINS-1:0] filt_prev_q;
    wire [NUM_PINS-1:0] filt_d = (sync2_q & sync3_q)
                               | (filt_q & (sync2_q ^ sync3_q));
    wire [NUM_PINS-1:0] pin_rise = filt_q & ~filt_prev_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            filt_q <= '0;
            filt_prev_q <= '0;
        end else begin
            sync1_q <= {external_count_input, fast_oscillator, slow_clock};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q <= filt_d;
            filt_prev_q <= filt_q;
        end
    end

    // Divider chains count conditioned edges; a tap ticks on its bit rising
    logic [SLOW_W-1:0] slow_div_q;
    logic [SLOW_W-1:0] slow_prev_q;
    logic [FAST_W-1:0] fast_div_q;
    logic [FAST_W-1:0] fast_prev_q;
    wire [SLOW_W-1:0] slow_divider_tap = slow_div_q & ~slow_prev_q;
    wire [FAST_W-1:0] fast_divider_tap = fast_div_q & ~fast_prev_q;
    wire fast_edge = pin_rise[PIN_FAST];
    wire ext_edge = pin_rise[PIN_EXT];

    // The chains run from reset whether a channel uses them or not, so the
    // first tick after a selector change can come early
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            slow_div_q <= '0;
            slow_prev_q <= '0;
            fast_div_q <= '0;
            fast_prev_q <= '0;
        end else begin
            slow_div_q <= slow_div_q + SLOW_W'(pin_rise[PIN_SLOW]);
            slow_prev_q <= slow_div_q;
            fast_div_q <= fast_div_q + FAST_W'(fast_edge);
            fast_prev_q <= fast_div_q;
        end
    end

    // Picks one channel's timer tick from its 4-bit selector code
    function automatic logic pick_tick(
        input logic [CFG_SRC_W-1:0] code,
        input int fast_top,
        input logic [SLOW_W-1:0] st,
        input logic [FAST_W-1:0] ft,
        input logic fedge,
        input logic casc
    );
        logic r;
        r = 1'b0;
        if (code[3]) begin
            // Fast taps run from the top division down by one per code
            if (fast_top == FAST_TOP_T01 && code[2:0] == SRC_FAST_LAST) begin
                r = fedge;
            end else begin
                r = ft[fast_top - int'(code[2:0])];
            end
        end else begin
            case (code)
                SRC_SLOW_4096: r = st[TAP_4096];
                SRC_SLOW_1024: r = st[TAP_1024];
                SRC_SLOW_256: r = st[TAP_256];
                SRC_SLOW_64: r = st[TAP_64];
                default: begin
                    if (code[2:1] == SRC_LOW_SLOW_TOP) begin
                        r = st[TAP_16384];
                    end else begin
                        r = casc;
                    end
                end
            endcase
        end
        return r;
    endfunction

    function automatic logic [IDX_W-1:0] ch_idx(
        input logic [IDX_W-1:0] base,
        input int ch
    );
        return base + IDX_W'(ch) * IDX_CH_STRIDE;
    endfunction

    // Register and channel state
    logic [NUM_CH-1:0][CNT_W-1:0] latch_q;
    logic [NUM_CH-1:0][CNT_W-1:0] cnt_q;
    logic [NUM_CH-1:0][REG_W-1:0] cfg_q;
    logic [NUM_CH-1:0] run_q;
    logic [NUM_CH-1:0] run_prev_q;
    logic [NUM_CH-1:0] b7_prev_q;
    logic [NUM_CH-1:0] sts_q;
    logic [NUM_CH-1:0] mask_q;
    logic stop_q;
    logic stop_seen_q;
    logic tone_q;
    logic [NUM_CH-1:0] exp_q;
    logic irq_q;

    logic [NUM_CH-1:0][CNT_W-1:0] latch_d;
    logic [NUM_CH-1:0][CNT_W-1:0] cnt_d;
    logic [NUM_CH-1:0][REG_W-1:0] cfg_d;
    logic [NUM_CH-1:0] run_d;
    logic [NUM_CH-1:0] exp_d;
    logic [NUM_CH-1:0] raw_tick;

    // Bus data-phase state
    trd_bus_type bus_q;
    logic wr_q;
    logic [IDX_W-1:0] idx_q;
    logic hit_q;
    logic [BUS_W-1:0] hrdata_q;
    logic hreadyout_q;
    logic [1:0] hresp_q;

    wire accept = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;
    wire [IDX_W-1:0] addr_idx = haddr[ADDR_LSB +: IDX_W];
    wire addr_hit = (haddr[BUS_W-1:ADDR_LSB+IDX_W] == '0)
                  & (haddr[ADDR_LSB-1:0] == '0);
    wire wr_en = wr_q & hit_q;
    wire [REG_W-1:0] wdata = hwdata[REG_W-1:0];

    wire [CFG_STOP_W-1:0] stop_mode = cfg_q[0][CFG_STOP_LSB +: CFG_STOP_W];
    wire start0 = run_q[0] & ~run_prev_q[0];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            logic casc;
            logic eff;
            logic running;
            logic start;
            logic reload;
            logic we_count;
            logic we_cfg;
            logic we_run;

            if (gi == 0) begin : g_first
                assign casc = ext_edge;
                // Timer0 alone can be halted by the stop logic
                assign eff = raw_tick[gi] & ~stop_q;
            end else begin : g_cascade
                // Bit 7 falling marks the upstream counter dropping below 128
                assign casc = b7_prev_q[gi-1]
                            & ~cnt_q[gi-1][CASCADE_BIT];
                assign eff = raw_tick[gi];
            end

            assign raw_tick[gi] = pick_tick(
                cfg_q[gi][CFG_SRC_LSB +: CFG_SRC_W],
                (gi == NUM_CH - 1) ? FAST_TOP_T2 : FAST_TOP_T01,
                slow_divider_tap, fast_divider_tap, fast_edge, casc);

            assign we_count = wr_en & (idx_q == ch_idx(IDX_COUNT0, gi));
            assign we_cfg = wr_en & (idx_q == ch_idx(IDX_CFG0, gi));
            assign we_run = wr_en & (idx_q == ch_idx(IDX_RUN0, gi));
            assign running = run_q[gi];
            // The enable is not aligned to the tick, so the first
            // period can run short by up to one tick
            assign start = running & ~run_prev_q[gi];
            assign reload = cfg_q[gi][CFG_RELOAD_BIT];

            assign latch_d[gi] = we_count ? wdata : latch_q[gi];
            assign cfg_d[gi] = we_cfg ? wdata : cfg_q[gi];
            assign run_d[gi] = we_run ? wdata[RUN_BIT] : run_q[gi];

            always_comb begin
                cnt_d[gi] = cnt_q[gi];
                if (start) begin
                    cnt_d[gi] = latch_q[gi];
                end else if (running & eff) begin
                    if (cnt_q[gi] != COUNT_ZERO) begin
                        cnt_d[gi] = cnt_q[gi] - COUNT_ONE;
                    end else if (reload) begin
                        cnt_d[gi] = latch_q[gi];
                    end
                    // One-shot stays at zero until the next start
                end
            end

            assign exp_d[gi] = running & eff & ~start
                             & (cnt_q[gi] == COUNT_ONE);
        end
    endgenerate

    // Timer0 clock stop: a full cycle is two rising edges after start
    // The tick that meets the condition still counts; the stop holds
    // from the next one until the channel is restarted or its stop mode is set to never
    wire stop_edge = (stop_mode == STOP_EXT_CYCLE) ? ext_edge
                   : (stop_mode == STOP_T2_CLK_CYCLE) ? raw_tick[2] : 1'b0;
    wire stop_set = run_q[0] & ~start0
                  & (((stop_mode == STOP_T2_EXPIRY) & exp_d[2])
                     | (stop_edge & stop_seen_q));
    wire stop_clr = start0 | ~run_q[0] | (stop_mode == STOP_NEVER);

    // Status: a new event wins over a same-cycle write-one clear
    wire w1c = wr_en & (idx_q == IDX_STATUS);
    wire [NUM_CH-1:0] sts_d = (sts_q & ~({NUM_CH{w1c}} & wdata[NUM_CH-1:0]))
                            | exp_d;
    wire [NUM_CH-1:0] mask_d = (wr_en & (idx_q == IDX_MASK))
                             ? wdata[NUM_CH-1:0] : mask_q;
    wire tone_en = cfg_q[0][CFG_TONE_BIT];
    wire tone_d = tone_en & (tone_q ^ exp_d[0]);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            latch_q <= '0;
            cnt_q <= '0;
            cfg_q <= {CFG_RST_T12, CFG_RST_T12, CFG_RST_T0};
            run_q <= '0;
            run_prev_q <= '0;
            b7_prev_q <= '0;
        end else begin
            latch_q <= latch_d;
            cnt_q <= cnt_d;
            cfg_q <= cfg_d;
            run_q <= run_d;
            run_prev_q <= run_q;
            // Cascade ticks lag the upstream counter by one cycle
            b7_prev_q <= {cnt_q[2][CASCADE_BIT], cnt_q[1][CASCADE_BIT],
                          cnt_q[0][CASCADE_BIT]};
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stop_q <= 1'b0;
            stop_seen_q <= 1'b0;
            sts_q <= '0;
            mask_q <= '0;
            tone_q <= 1'b0;
            exp_q <= '0;
            irq_q <= 1'b0;
        end else begin
            stop_q <= ~stop_clr & (stop_q | stop_set);
            stop_seen_q <= ~stop_clr & (stop_seen_q | stop_edge);
            sts_q <= sts_d;
            mask_q <= mask_d;
            tone_q <= tone_d;
            exp_q <= exp_d;
            irq_q <= |(sts_d & mask_d);
        end
    end

    // Read mux; counter values live in this clock domain already
    logic [REG_W-1:0] rd_byte;
    always_comb begin
        rd_byte = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (idx_q == ch_idx(IDX_COUNT0, i)) begin
                rd_byte = cnt_q[i];
            end
            if (idx_q == ch_idx(IDX_CFG0, i)) begin
                rd_byte = cfg_q[i];
            end
            if (idx_q == ch_idx(IDX_RUN0, i)) begin
                rd_byte = REG_W'(run_q[i]);
            end
        end
        if (idx_q == IDX_STATUS) begin
            rd_byte = REG_W'(sts_q);
        end
        if (idx_q == IDX_MASK) begin
            rd_byte = REG_W'(mask_q);
        end
        // Off-map addresses read zero so they never alias a register
        if (!hit_q) begin
            rd_byte = '0;
        end
    end

    // Reads take one wait state so a write just before is already visible
    // Transfer size is not decoded: each register is one word, and only
    // the low byte of the data carries anything
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_q <= BUS_IDLE;
            wr_q <= 1'b0;
            idx_q <= '0;
            hit_q <= 1'b0;
            hrdata_q <= '0;
            hreadyout_q <= 1'b1;
        end else begin
            case (bus_q)
                BUS_IDLE: begin
                    wr_q <= accept & hwrite;
                    if (accept) begin
                        idx_q <= addr_idx;
                        hit_q <= addr_hit;
                    end
                    if (accept & ~hwrite) begin
                        bus_q <= BUS_RDWAIT;
                        hreadyout_q <= 1'b0;
                    end
                end
                BUS_RDWAIT: begin
                    hrdata_q <= {{(BUS_W-REG_W){1'b0}}, rd_byte};
                    hreadyout_q <= 1'b1;
                    bus_q <= BUS_IDLE;
                end
                default: begin
                    bus_q <= BUS_IDLE;
                    hreadyout_q <= 1'b1;
                end
            endcase
        end
    end

    // Response is registered like every other output; it never leaves OKAY
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hresp_q <= HRESP_OKAY;
        end else begin
            hresp_q <= HRESP_OKAY;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign channel_expiry = exp_q;
    assign tone_out = tone_q;
    assign irq = irq_q;

endmodule

// file: hw/trd_pkg.sv
package trd_pkg;

    localparam int NUM_CH = 3;
    localparam int CNT_W = 8;
    localparam int REG_W = 8;
    localparam int BUS_W = 32;
    localparam int IDX_W = 8;

    // Register indices; byte address is index shifted by ADDR_LSB
    localparam int ADDR_LSB = 2;
    localparam logic [IDX_W-1:0] IDX_COUNT0 = 8'h00;
    localparam logic [IDX_W-1:0] IDX_CFG0 = 8'h01;
    localparam logic [IDX_W-1:0] IDX_RUN0 = 8'h02;
    localparam logic [IDX_W-1:0] IDX_CH_STRIDE = 8'h04;
    localparam logic [IDX_W-1:0] IDX_STATUS = 8'h0C;
    localparam logic [IDX_W-1:0] IDX_MASK = 8'h0D;

    // Clock-config fields
    localparam int CFG_SRC_LSB = 0;
    localparam int CFG_SRC_W = 4;
    localparam int CFG_RELOAD_BIT = 4;
    localparam int CFG_TONE_BIT = 5;
    localparam int CFG_STOP_LSB = 6;
    localparam int CFG_STOP_W = 2;
    localparam int RUN_BIT = 0;

    localparam logic [REG_W-1:0] CFG_RST_T0 = 8'h3E;
    localparam logic [REG_W-1:0] CFG_RST_T12 = 8'h1E;
    localparam logic [CNT_W-1:0] COUNT_RST = 8'h00;
    localparam logic [CNT_W-1:0] COUNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] COUNT_ZERO = 8'h00;
    localparam int CASCADE_BIT = 7;

    // Clock selector codes
    localparam logic [1:0] SRC_LOW_CASCADE = 2'h0;
    localparam logic [1:0] SRC_LOW_SLOW_TOP = 2'h1;
    localparam logic [3:0] SRC_SLOW_4096 = 4'h4;
    localparam logic [3:0] SRC_SLOW_1024 = 4'h5;
    localparam logic [3:0] SRC_SLOW_256 = 4'h6;
    localparam logic [3:0] SRC_SLOW_64 = 4'h7;
    localparam logic [2:0] SRC_FAST_LAST = 3'h7;

    // Divider chains and the bit of each tap
    localparam int SLOW_W = 14;
    localparam int FAST_W = 9;
    localparam int TAP_16384 = 13;
    localparam int TAP_4096 = 11;
    localparam int TAP_1024 = 9;
    localparam int TAP_256 = 7;
    localparam int TAP_64 = 5;
    localparam int FAST_TOP_T01 = 6;
    localparam int FAST_TOP_T2 = 8;

    localparam logic [1:0] STOP_NEVER = 2'h0;
    localparam logic [1:0] STOP_T2_EXPIRY = 2'h1;
    localparam logic [1:0] STOP_EXT_CYCLE = 2'h2;
    localparam logic [1:0] STOP_T2_CLK_CYCLE = 2'h3;

    localparam int PIN_SLOW = 0;
    localparam int PIN_FAST = 1;
    localparam int PIN_EXT = 2;
    localparam int NUM_PINS = 3;

    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_RDWAIT = 1'b1
    } trd_bus_type;

endpackage

// file: verification/trd_timer_sva.sv
module trd_timer_sva
    import trd_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [BUS_W-1:0] hrdata,
    input wire logic hreadyout,
    input wire logic [1:0] hresp,
    input wire logic [NUM_CH-1:0] channel_expiry,
    input wire logic tone_out,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // Cycles since the last write was taken, saturating at 7
    logic [2:0] wr_age_q;
    logic [2:0] wr_age_d;
    wire logic taken = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
    assign wr_age_d = (taken && hwrite) ? 3'h0 :
        (wr_age_q == 3'h7) ? wr_age_q : wr_age_q + 3'h1;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_age_q <= 3'h7;
        end else begin
            wr_age_q <= wr_age_d;
        end
    end

    sequence s_rd_taken;
        taken && !hwrite;
    endsequence
    sequence s_rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence

    AST_READ_WAIT: assert property (s_rd_taken |=> s_rd_answer)
        else $error("read not answered after one wait cycle");
    AST_WRITE_NOWAIT: assert property (taken && hwrite |=> hreadyout)
        else $error("write inserted a wait state");
    AST_RESP_OKAY: assert property (hresp == HRESP_OKAY)
        else $error("response not okay");
    AST_RDATA_HOLD: assert property (
        !$rose(hreadyout) |-> $stable(hrdata))
        else $error("read data moved without a completed read");
    AST_RDATA_UPPER: assert property (hrdata[BUS_W-1:8] == '0)
        else $error("read data upper bits not zero");
    AST_EXPIRY_PULSE: assert property (channel_expiry != '0 |=>
        (channel_expiry & $past(channel_expiry)) == '0)
        else $error("expiry pulse longer than one cycle");
    AST_TONE_CAUSE: assert property ($changed(tone_out) |->
        channel_expiry[0] || $past(channel_expiry[0]) || wr_age_q <= 3'h3)
        else $error("tone changed without expiry or write");
    AST_IRQ_CLEAR: assert property ($fell(irq) |-> wr_age_q <= 3'h4)
        else $error("interrupt dropped without a write");
endmodule

bind trd_timer trd_timer_sva u_sva (.core_clk, .arst_n, .hsel, .htrans,
    .hwrite, .hready, .hrdata, .hreadyout, .hresp, .channel_expiry,
    .tone_out, .irq);

// file: verification/triple_reload_down_timer_tb.sv
module triple_reload_down_timer_tb
    import trd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel, hwrite, hready, hreadyout, tone_out, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, hresp;
    logic [2:0] hsize;
    logic [NUM_PINS-1:0] pins;
    logic [NUM_CH-1:0] channel_expiry;
    int errors, checked;
    int cnt[NUM_CH], lat[NUM_CH], rl[NUM_CH], expm[NUM_CH], seen[NUM_CH];

    assign hready = hreadyout;
    always #2 core_clk = ~core_clk;

    trd_timer uut (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .slow_clock(pins[PIN_SLOW]), .fast_oscillator(pins[PIN_FAST]),
        .external_count_input(pins[PIN_EXT]),
        .channel_expiry(channel_expiry), .tone_out(tone_out), .irq(irq));

    always @(posedge core_clk) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (arst_n && channel_expiry[c] === 1'b1) seen[c]++;
        end
    end

    task automatic results;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h got %h", n, e, g);
        end
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1) begin
            errors++;
            $display("[FAIL] hready expected 1 got %b", hready);
            results();
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] v;
        bus(1'b1, a, {24'h0, d}, v);
    endtask

    task automatic rdc(input string n, input logic [31:0] a,
                       input logic [31:0] e);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        chk(n, e, v);
    endtask

    function automatic logic [31:0] ra(input int ch,
                                       input logic [IDX_W-1:0] idx);
        return (32'(idx) + 32'(ch) * 32'(IDX_CH_STRIDE)) << ADDR_LSB;
    endfunction

    // Rising edges, each level held long enough for the pin conditioning
    task automatic pulse(input int p, input int n);
        repeat (n) begin
            pins[p] <= 1'b1;
            repeat (4) @(posedge core_clk);
            pins[p] <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
        repeat (8) @(posedge core_clk);
    endtask

    task automatic mtick(input int ch);
        if (cnt[ch] == 0) begin
            if (rl[ch] != 0) cnt[ch] = lat[ch];
        end else begin
            cnt[ch]--;
            if (cnt[ch] == 0) expm[ch]++;
        end
    endtask

    // Stopped while the selector moves, so a mux glitch is not counted
    task automatic start(input int ch, input logic [7:0] cfg,
                         input logic [7:0] l);
        wr(ra(ch, IDX_RUN0), 8'h00);
        wr(ra(ch, IDX_CFG0), cfg);
        wr(ra(ch, IDX_COUNT0), l);
        wr(ra(ch, IDX_RUN0), 8'h01);
        lat[ch] = l;
        cnt[ch] = l;
        rl[ch] = cfg[CFG_RELOAD_BIT];
        repeat (2) @(posedge core_clk);
    endtask

    initial begin
        logic [7:0] r;
        {hsel, hwrite, haddr, hwdata, htrans, pins} = '0;
        hsize = 3'h2;
        errors = 0;
        checked = 0;
        foreach (cnt[c]) begin
            {cnt[c], lat[c], rl[c], expm[c], seen[c]} = '0;
        end
        void'($urandom(32'hC543B3CA));
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        for (int c = 0; c < NUM_CH; c++) begin
            rdc("cfg", ra(c, IDX_CFG0), c == 0 ? 32'h3E : 32'h1E);
            rdc("run", ra(c, IDX_RUN0), 32'h0);
            rdc("count", ra(c, IDX_COUNT0), 32'h0);
        end
        rdc("unmapped", 32'h3C, 32'h0);
        r = 8'($urandom);
        wr(ra(2, IDX_CFG0), r);
        rdc("cfg2", ra(2, IDX_CFG0), {24'h0, r});
        for (int m = 1; m >= 0; m--) begin
            start(0, m != 0 ? 8'h30 : 8'h20, 8'(2 + $urandom % 4));
            for (int k = 0; k < 8; k++) begin
                pulse(PIN_EXT, 1);
                mtick(0);
                rdc("t0", ra(0, IDX_COUNT0), 32'(cnt[0]));
            end
            chk("expiries", 32'(expm[0]), 32'(seen[0]));
            chk("tone", 32'(expm[0] % 2), {31'h0, tone_out});
        end
        rdc("status", ra(0, IDX_STATUS), 32'h1);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(ra(0, IDX_MASK), 8'h01);
        repeat (2) @(posedge core_clk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(ra(0, IDX_STATUS), 8'h01);
        repeat (2) @(posedge core_clk);
        chk("irq clear", 32'h0, {31'h0, irq});
        rdc("status", ra(0, IDX_STATUS), 32'h0);
        wr(ra(0, IDX_CFG0), 8'h10);
        repeat (2) @(posedge core_clk);
        chk("tone off", 32'h0, {31'h0, tone_out});
        start(2, 8'h10, 8'h05);
        start(1, 8'h10, 8'h80);
        start(0, 8'h10, 8'h80);
        pulse(PIN_EXT, 1);
        mtick(0);
        mtick(1);
        mtick(2);
        rdc("t0", ra(0, IDX_COUNT0), 32'(cnt[0]));
        rdc("t1 cascade", ra(1, IDX_COUNT0), 32'(cnt[1]));
        rdc("t2 cascade", ra(2, IDX_COUNT0), 32'(cnt[2]));
        // Stop after a full input cycle: two edges count, later ones not
        start(0, 8'h90, 8'h10);
        pulse(PIN_EXT, 4);
        repeat (2) mtick(0);
        rdc("t0 stop", ra(0, IDX_COUNT0), 32'(cnt[0]));
        for (int c = 8; c < 16; c++) begin
            start(1, 8'(8'h10 | c), 8'hFF);
            start(2, 8'(8'h10 | c), 8'hFF);
            pulse(PIN_FAST, 1 << (17 - c));
            repeat (4) mtick(1);
            mtick(2);
            rdc("t1 fast", ra(1, IDX_COUNT0), 32'(cnt[1]));
            rdc("t2 fast", ra(2, IDX_COUNT0), 32'(cnt[2]));
        end
        for (int c = 4; c < 8; c++) begin
            start(0, 8'(8'h10 | c), 8'hFF);
            pulse(PIN_SLOW, 64 << (2 * (7 - c)));
            mtick(0);
            rdc("t0 slow", ra(0, IDX_COUNT0), 32'(cnt[0]));
        end
        results();
    end
endmodule
